// File: common/pvs_pkg.sv
// constants for the core/usim supply two-wire slave
package pvs_pkg;
    // fixed upper address bits a7..a2, a1 comes from the strap pin
    localparam logic [5:0] ADDR_HIGH      = 6'h0a;
    localparam int         ADDR_BITS      = 7;
    localparam int         DATA_BITS      = 8;
    // command byte fields
    localparam int         TARGET_BIT     = 5;
    localparam int         CORE_MSB       = 4;
    localparam int         USIM_MSB       = 1;
    // reset values: core 1.3 v, usim 0 v
    localparam logic [4:0] CORE_RESET     = 5'h18;
    localparam logic [1:0] USIM_RESET     = 2'h0;
    // synchroniser depth for pin inputs
    localparam int         SYNC_STAGES    = 3;
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_DATA,
        ST_DATA_ACK
    } pvs_state_type;
endpackage

// File: src/pvs_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pvs_sync
(
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed
    {
        logic [2:0] stage;
        logic       level;
    } pvs_sync_state_type;

    pvs_sync_state_type s_reg;
    pvs_sync_state_type s_next;

    // idle bus is high, so reset the chain high
    always_comb
    begin
        s_next = s_reg;
        s_next.stage = {s_reg.stage[1:0], pin_i};
        // first stage only feeds the second; stages two and three vote
        if (s_reg.stage[1] == s_reg.stage[2])
        begin
            s_next.level = s_reg.stage[2];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_reg <= '{stage: 3'h7, level: 1'b1};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign level_o = s_reg.level;
endmodule

// File: src/pvs_slave.sv
// write-only two-wire slave programming core and usim supply codes
// Operation
// - slave runs only while a regulator enabled
// - target bit low loads core code
// - target bit high loads usim code
// - power-up core 1.3 v, usim 0 v
// - slave only, never drives clock
// - acknowledge address and command in ninth clock
// - sda stable while clock is high
// - sda fall is start, rise is stop
// - lines released high when bus idle
// - after stop or mismatch ignore until start
// - compare address bit by bit, abandon early
// - address bit a1 follows strap pin
// - manual reset low restores core default
`timescale 1ns/1ps
module pvs_slave
(
    input  wire logic       clk_i,
    input  wire logic       rstn_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_o,
    input  wire logic [5:0] regulator_enable_inputs_i,
    input  wire logic       slave_address_select_pin_i,
    input  wire logic       manual_reset_input_n_i,
    output logic [4:0]      core_supply_code_o,
    output logic [1:0]      usim_supply_code_o,
    output logic            slave_active_o
);
    typedef struct packed
    {
        pvs_pkg::pvs_state_type state;
        logic                   scl_d;
        logic                   sda_d;
        logic [3:0]             bit_cnt;
        logic [7:0]             shift;
        logic                   ack_drive;
        logic                   addr_bit_a1;
        logic                   en_sync1;
        logic                   en_sync2;
        logic                   en_sync3;
        logic                   enabled;
        logic                   mr_sync1;
        logic                   mr_sync2;
        logic                   mr_sync3;
        logic                   mr_low;
        logic [4:0]             core_code;
        logic [1:0]             usim_code;
    } pvs_slave_state_type;

    pvs_slave_state_type s_reg;
    pvs_slave_state_type s_next;
    logic                scl_s;
    logic                sda_s;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_cond;
    logic                stop_cond;
    logic [6:0]          own_addr;

    // bus pins cross into the local clock here
    pvs_sync u_scl_sync
    (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .pin_i   (scl_i),
        .level_o (scl_s)
    );

    pvs_sync u_sda_sync
    (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .pin_i   (sda_i),
        .level_o (sda_s)
    );

    // bus conditions seen on the filtered lines
    assign scl_rise   = scl_s & ~s_reg.scl_d;
    assign scl_fall   = ~scl_s & s_reg.scl_d;
    assign start_cond = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
    assign stop_cond  = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
    assign own_addr   = {pvs_pkg::ADDR_HIGH, s_reg.addr_bit_a1};

    // protocol engine and code registers
    always_comb
    begin
        s_next = s_reg;
        s_next.scl_d = scl_s;
        s_next.sda_d = sda_s;
        // enable and manual reset are pins: same three-stage vote
        s_next.en_sync1 = |regulator_enable_inputs_i;
        s_next.en_sync2 = s_reg.en_sync1;
        s_next.en_sync3 = s_reg.en_sync2;
        if (s_reg.en_sync2 == s_reg.en_sync3)
        begin
            s_next.enabled = s_reg.en_sync3;
        end
        s_next.mr_sync1 = ~manual_reset_input_n_i;
        s_next.mr_sync2 = s_reg.mr_sync1;
        s_next.mr_sync3 = s_reg.mr_sync2;
        if (s_reg.mr_sync2 == s_reg.mr_sync3)
        begin
            s_next.mr_low = s_reg.mr_sync3;
        end
        // strap sampled every cycle after reset release
        s_next.addr_bit_a1 = slave_address_select_pin_i;

        if (!s_reg.enabled)
        begin
            // shut down: drop any transfer, release sda
            s_next.state     = pvs_pkg::ST_IDLE;
            s_next.ack_drive = 1'b0;
        end
        else if (stop_cond)
        begin
            // partial bytes are discarded, codes untouched
            s_next.state     = pvs_pkg::ST_IDLE;
            s_next.ack_drive = 1'b0;
        end
        else if (start_cond)
        begin
            s_next.state     = pvs_pkg::ST_ADDR;
            s_next.bit_cnt   = 4'h0;
            s_next.ack_drive = 1'b0;
        end
        else
        begin
            case (s_reg.state)
                pvs_pkg::ST_IDLE:
                begin
                    // clock ignored until next start
                    s_next.ack_drive = 1'b0;
                end
                pvs_pkg::ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        // msb first; bit 0 of the byte is r/w
                        if (s_reg.bit_cnt < 4'(pvs_pkg::ADDR_BITS))
                        begin
                            if (sda_s != own_addr[3'(6 - s_reg.bit_cnt)])
                            begin
                                s_next.state = pvs_pkg::ST_IDLE;
                            end
                        end
                        else if (sda_s)
                        begin
                            // reads unsupported: no ack, go quiet
                            s_next.state = pvs_pkg::ST_IDLE;
                        end
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall
                             && s_reg.bit_cnt == 4'(pvs_pkg::DATA_BITS))
                    begin
                        s_next.state     = pvs_pkg::ST_ADDR_ACK;
                        s_next.ack_drive = 1'b1;
                    end
                end
                pvs_pkg::ST_ADDR_ACK:
                begin
                    // release after the ninth clock falls
                    if (scl_fall)
                    begin
                        s_next.ack_drive = 1'b0;
                        s_next.state     = pvs_pkg::ST_DATA;
                        s_next.bit_cnt   = 4'h0;
                    end
                end
                pvs_pkg::ST_DATA:
                begin
                    if (scl_rise)
                    begin
                        s_next.shift   = {s_reg.shift[6:0], sda_s};
                        s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                    end
                    else if (scl_fall
                             && s_reg.bit_cnt == 4'(pvs_pkg::DATA_BITS))
                    begin
                        s_next.state     = pvs_pkg::ST_DATA_ACK;
                        s_next.ack_drive = 1'b1;
                    end
                end
                pvs_pkg::ST_DATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        // byte complete and acknowledged: commit now
                        s_next.ack_drive = 1'b0;
                        s_next.state     = pvs_pkg::ST_IDLE;
                        if (s_reg.shift[pvs_pkg::TARGET_BIT])
                        begin
                            s_next.usim_code =
                                s_reg.shift[pvs_pkg::USIM_MSB:0];
                        end
                        else
                        begin
                            s_next.core_code =
                                s_reg.shift[pvs_pkg::CORE_MSB:0];
                        end
                    end
                end
                default:
                begin
                    s_next.state     = pvs_pkg::ST_IDLE;
                    s_next.ack_drive = 1'b0;
                end
            endcase
        end
        // manual reset overrides a core write in the same cycle
        if (s_reg.mr_low)
        begin
            s_next.core_code = pvs_pkg::CORE_RESET;
        end
    end

    // state register; defaults reflect power-up codes
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            s_reg <= '{state: pvs_pkg::ST_IDLE, scl_d: 1'b1, sda_d: 1'b1,
                       bit_cnt: 4'h0, shift: 8'h00, ack_drive: 1'b0,
                       addr_bit_a1: 1'b0, en_sync1: 1'b0, en_sync2: 1'b0,
                       en_sync3: 1'b0, enabled: 1'b0, mr_sync1: 1'b0,
                       mr_sync2: 1'b0, mr_sync3: 1'b0, mr_low: 1'b0,
                       core_code: pvs_pkg::CORE_RESET,
                       usim_code: pvs_pkg::USIM_RESET};
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // only sda is ever driven, and only low; scl has no driver at all
    assign sda_o              = 1'b0;
    assign sda_oe_o           = s_reg.ack_drive;
    assign core_supply_code_o = s_reg.core_code;
    assign usim_supply_code_o = s_reg.usim_code;
    assign slave_active_o     = s_reg.enabled;

    // sda released whenever idle or shut down; ack timed on filtered scl
    a_idle_release: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (s_reg.state == pvs_pkg::ST_IDLE) |-> !sda_oe_o)
        else $error("sda driven while idle");
    a_shutdown_idle: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        !s_reg.enabled |=> s_reg.state == pvs_pkg::ST_IDLE)
        else $error("slave active while no regulator enabled");
    a_ack_starts_low: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(sda_oe_o) |-> !scl_s)
        else $error("ack raised while clock high");
    a_ack_whole_period: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (sda_oe_o && !scl_fall && s_reg.enabled && !start_cond && !stop_cond)
        |=> sda_oe_o)
        else $error("ack not held through ninth clock");
    a_ack_on_scl_low: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $changed(sda_oe_o) |-> !s_reg.scl_d || !scl_s)
        else $error("sda changed while clock high");
    a_mr_default: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        s_reg.mr_low |=> core_supply_code_o == pvs_pkg::CORE_RESET)
        else $error("manual reset did not restore core code");
    a_commit_only_ack: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ($changed(usim_supply_code_o)
         || ($changed(core_supply_code_o) && !$past(s_reg.mr_low)))
        |-> $past(s_reg.state) == pvs_pkg::ST_DATA_ACK)
        else $error("code changed outside data acknowledge");
    a_mismatch_quiet: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (s_reg.state == pvs_pkg::ST_IDLE && !start_cond)
        |=> s_reg.state == pvs_pkg::ST_IDLE)
        else $error("left idle without start");
    a_start_to_addr: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (start_cond && s_reg.enabled && !stop_cond)
        |=> s_reg.state == pvs_pkg::ST_ADDR && s_reg.bit_cnt == 4'h0)
        else $error("start not taken");
endmodule

// File: verification/pvs_master.sv
// two-wire bus master model that drives the slave's pins
`timescale 1ns/1ps
module pvs_master
(
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // both lines released high while idle
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // n clock periods, every move lands on a falling edge
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // from idle or just after a clock fall: sda falls, scl high
    task automatic start();
        w(2);
        sda_o = 1'b1;
        w(2);
        scl_o = 1'b1;
        w(4);
        sda_o = 1'b0;
        w(4);
        scl_o = 1'b0;
    endtask
    // sda rises while scl high, bus freed
    task automatic stop();
        w(2);
        sda_o = 1'b0;
        w(4);
        scl_o = 1'b1;
        w(2);
        sda_o = 1'b1;
        w(4);
    endtask
    // 800 ns bit: long low phase so the slave's filtered ack lands
    // before scl rises; data steady across the high phase
    task automatic bit_io(input logic b, output logic s);
        w(2);
        sda_o = b;
        w(4);
        scl_o = 1'b1;
        w(2);
        s = sda_i;
        scl_o = 1'b0;
    endtask
    // eight bits msb first, then a released ninth bit
    task automatic send(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
endmodule

// File: verification/tb_top.sv
// self-checking bench for the supply-code two-wire slave
`timescale 1ns/1ps
module tb_top;
    logic       clk_i       = 1'b0;
    logic       rstn_i      = 1'b0;
    logic [5:0] en          = 6'h00;
    logic       strap       = 1'b0;
    logic       mr_n        = 1'b1;
    logic       scl;
    logic       m_sda;
    logic       oe;
    logic       sd0;
    logic       act;
    logic [4:0] core;
    logic [1:0] usim;
    wire        sda;
    int         err_total   = 0;
    int         comparisons = 0;
    int         e_core      = (1300 - 700) / 25;
    int         e_usim      = 0;

    // open-drain data line with pull-up
    assign sda = m_sda & ~(oe & ~sd0);
    always #50 clk_i = ~clk_i;

    pvs_slave uut
    (
        .clk_i                      (clk_i),
        .rstn_i                     (rstn_i),
        .scl_i                      (scl),
        .sda_i                      (sda),
        .sda_o                      (sd0),
        .sda_oe_o                   (oe),
        .regulator_enable_inputs_i  (en),
        .slave_address_select_pin_i (strap),
        .manual_reset_input_n_i     (mr_n),
        .core_supply_code_o         (core),
        .usim_supply_code_o         (usim),
        .slave_active_o             (act)
    );
    pvs_master m
    (
        .clk_i (clk_i),
        .sda_i (sda),
        .scl_o (scl),
        .sda_o (m_sda)
    );

    task automatic chk(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", n, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one write; the model decides the acknowledges and new codes
    task automatic xfer(input logic [6:0] a, input logic rw,
                        input logic [7:0] d);
        logic ka;
        logic kd;
        logic ok;
        ok = (en != 6'h00) && (a == {pvs_pkg::ADDR_HIGH, strap}) && !rw;
        m.start();
        m.send({a, rw}, ka);
        chk("addr_ack", ka, ok);
        m.send(d, kd);
        chk("data_ack", kd, ok);
        m.stop();
        if (ok && d[5])
            e_usim = d[1:0];
        else if (ok)
            e_core = d[4:0];
        repeat (4) @(negedge clk_i);
        chk("core", core, e_core[7:0]);
        chk("usim", usim, e_usim[7:0]);
    endtask

    // address accepted, then five data bits before the cut
    task automatic cut();
        logic s;
        m.start();
        m.send({pvs_pkg::ADDR_HIGH, strap, 1'b0}, s);
        repeat (5) m.bit_io(1'b1, s);
    endtask

    initial
    begin
        logic [7:0] d;
        int         k;
        k = $urandom(32'h470976eb);
        repeat (10) @(negedge clk_i);
        rstn_i = 1'b1;
        chk("core_rst", core, e_core[7:0]);
        chk("usim_rst", usim, e_usim[7:0]);
        chk("act_off", act, 8'h00);
        // no regulator enabled: slave must stay deaf
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            en = 6'h01 << i;
            repeat (8) @(negedge clk_i);
            chk("act_on", act, 8'h01);
        end
        en = $urandom_range(63, 1);
        for (int i = 0; i < 16; i++)
        begin
            strap = $urandom;
            d = $urandom;
            if (i < 4)
                d = {d[7:6], 1'b1, d[4:2], i[1:0]};
            xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, d);
        end
        // one wrong address bit at each position, then a read
        for (int i = 0; i < 7; i++)
        begin
            d = $urandom;
            xfer({pvs_pkg::ADDR_HIGH, strap} ^ (7'h01 << i), 1'b0, d);
        end
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b1, 8'h0f);
        // command byte cut by stop, then by a repeated start
        cut();
        m.stop();
        repeat (4) @(negedge clk_i);
        chk("core_cut", core, e_core[7:0]);
        chk("usim_cut", usim, e_usim[7:0]);
        cut();
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, 8'h05);
        mr_n = 1'b0;
        repeat (6) @(negedge clk_i);
        e_core = (1300 - 700) / 25;
        chk("core_mr", core, e_core[7:0]);
        chk("usim_mr", usim, e_usim[7:0]);
        mr_n = 1'b1;
        en = 6'h00;
        repeat (8) @(negedge clk_i);
        chk("act_drop", act, 8'h00);
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, 8'h07);
        // unanswered attempt repeated once a regulator is back on
        en = $urandom_range(63, 1);
        repeat (8) @(negedge clk_i);
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, 8'h07);
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, 8'h23);
        // mid-run reset brings back the power-up codes
        rstn_i = 1'b0;
        repeat (3) @(negedge clk_i);
        rstn_i = 1'b1;
        e_core = (1300 - 700) / 25;
        e_usim = 0;
        chk("core_rst2", core, e_core[7:0]);
        chk("usim_rst2", usim, e_usim[7:0]);
        chk("act_rst2", act, 8'h00);
        repeat (8) @(negedge clk_i);
        xfer({pvs_pkg::ADDR_HIGH, strap}, 1'b0, 8'h3e);
        conclude();
    end

    // hang guard, far beyond the expected run length
    initial
    begin
        #(20000 * 100);
        err_total++;
        conclude();
    end
endmodule
